// *** src/aic_channels.sv ***
// analog input channel processing: raw value, configuration, unit code, scaled value
// assumes object requests come from the node's protocol engine on clk_i; adc samples are
// same-domain words with a scan strobe, status flags are fault inputs from the converter
//
// Function
// RQ1 - raw converter value per channel, read only, unscaled
// RQ2 - low byte of configuration selects sensor type
// RQ3 - bit 13 picks lower limit on overflow, else upper limit
// RQ4 - bit 14 clear suppresses single interference pulses; set disables it
// RQ5 - bit 15 set makes channel inactive, process value reads zero
// RQ6 - bits 13 and 15 writable alone without touching sensor type; code writes the whole word, sensor type included
// RQ7 - master should set bit 14 for fast signals
// RQ8 - step over 5 percent of range within one scan counts as pulse
// RQ9 - signed 16-bit scaled process value per channel, read only
// RQ10 - decimal places fixed per unit, not settable
// RQ11 - rtd scaled in tenths of a degree, -2000 to +8500
// RQ12 - voltage in millivolts, 0..10000 or -10000..+10000
// RQ13 - current in microamperes, 0..20000 or 0..16000
// RQ14 - breakage or short sets status and drives limit value
// RQ15 - unit code held in upper twelve bits
// RQ16 - low four bits hold decimal scale factor
// RQ17 - status bit 0 invalid, bits 1..4 over, under, cal, fault limit
`timescale 1ns/1ps
`include "aic_params.svh"
module aic_channels #(
    parameter int NCH = 16,
    parameter int SCAN_MIN_CYC = `AIC_SCAN_MIN_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire aic_pkg::aic_obj_req_t req_i,
    input wire logic sample_valid_i,
    input wire logic [3:0] sample_ch_i,
    input wire logic [15:0] sample_i,
    input wire logic sensor_fault_i,
    input wire logic cal_fault_i,
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [15:0] rsp_data_o
);
    import aic_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] raw_reg [NCH];
    logic [15:0] cfg_reg [NCH];
    logic [15:0] unit_reg [NCH];
    logic signed [15:0] pv_reg [NCH];
    logic [7:0] stat_reg [NCH];
    logic [3:0] fcnt_reg [NCH];
    // age saturates so a long idle channel never opens a false pulse window
    logic [31:0] age_reg [NCH];
    logic [15:0] raw_next [NCH];
    logic [15:0] cfg_next [NCH];
    logic [15:0] unit_next [NCH];
    logic signed [15:0] pv_next [NCH];
    logic [7:0] stat_next [NCH];
    logic [3:0] fcnt_next [NCH];
    logic [31:0] age_next [NCH];
    logic rsp_valid_reg, rsp_valid_next, rsp_err_reg, rsp_err_next;
    logic [15:0] rsp_data_reg, rsp_data_next;

    // ************************************************************
    // scaling helpers
    // ************************************************************
    // ends of the documented output range per sensor type, used for scaling and as sensor fault values
    function automatic logic signed [16:0] lo_lim(input logic [7:0] t);
        case (t)
            AIC_RTD: lo_lim = -17'sd2000; // RQ11
            AIC_V_BI: lo_lim = -17'sd10000; // RQ12
            AIC_V_UNI, AIC_I_420, AIC_I_020: lo_lim = 17'sd0; // RQ12 RQ13
            default: lo_lim = -17'sd2700; // RQ2
        endcase
    endfunction
    function automatic logic signed [16:0] hi_lim(input logic [7:0] t);
        case (t)
            AIC_RTD: hi_lim = 17'sd8500; // RQ11
            AIC_V_UNI, AIC_V_BI: hi_lim = 17'sd10000; // RQ12
            AIC_I_020: hi_lim = 17'sd20000; // RQ13
            AIC_I_420: hi_lim = 17'sd16000; // RQ13
            default: hi_lim = 17'sd22993; // RQ2
        endcase
    endfunction
    // linear map of the unsigned converter word onto the fixed-decimal range
    // truncating shift: full scale lands one step short of the top limit
    function automatic logic signed [15:0] scale(input logic [7:0] t, input logic [15:0] raw);
        logic signed [16:0] lo;
        logic signed [17:0] span;
        logic signed [35:0] prod;
        lo = lo_lim(t);
        span = 18'(hi_lim(t)) - 18'(lo);
        prod = 36'(span) * $signed({20'h0, raw});
        scale = 16'(18'(lo) + 18'(prod >>> 16)); // RQ10
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [15:0] step;
        logic signed [15:0] sc;
        step = 16'h0;
        sc = 16'sh0;
        rsp_valid_next = 1'b0;
        rsp_err_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        for (int c = 0; c < NCH; c++) begin
            raw_next[c] = raw_reg[c];
            cfg_next[c] = cfg_reg[c];
            unit_next[c] = unit_reg[c];
            pv_next[c] = pv_reg[c];
            stat_next[c] = stat_reg[c];
            fcnt_next[c] = fcnt_reg[c];
            age_next[c] = (age_reg[c] == 32'hffffffff) ? age_reg[c] : age_reg[c] + 32'h1;
        end
        if (sample_valid_i && 32'(sample_ch_i) < NCH) begin
            for (int c = 0; c < NCH; c++) begin
                if (4'(c) == sample_ch_i) begin
                    step = (sample_i > raw_reg[c]) ? sample_i - raw_reg[c]
                                                    : raw_reg[c] - sample_i;
                    raw_next[c] = sample_i; // RQ1
                    age_next[c] = 32'h0;
                    sc = scale(cfg_reg[c][7:0], sample_i); // RQ9 RQ11 RQ12 RQ13
                    stat_next[c] = 8'h0;
                    // 5 percent of the 16-bit range, compared as step*100 > pct*65536
                    if (!cfg_reg[c][`AIC_BIT_NOSUP] && age_reg[c] <= 32'(SCAN_MIN_CYC) * 8
                        && 32'(step) * 100 > `AIC_SPIKE_PCT * 65536) begin // RQ4 RQ8
                        sc = pv_reg[c]; // hold previous value, drop the pulse
                        if (fcnt_reg[c] != 4'hf) fcnt_next[c] = fcnt_reg[c] + 4'h1;
                    end else if (fcnt_reg[c] != 4'h0) begin
                        fcnt_next[c] = fcnt_reg[c] - 4'h1;
                    end
                    if (sensor_fault_i) begin // RQ14
                        stat_next[c][`AIC_ST_INVALID] = 1'b1; // RQ17
                        if (cfg_reg[c][`AIC_BIT_LOWLIM]) begin // RQ3
                            sc = 16'(lo_lim(cfg_reg[c][7:0]));
                            stat_next[c][`AIC_ST_UNDER] = 1'b1;
                        end else begin
                            sc = 16'(hi_lim(cfg_reg[c][7:0]));
                            stat_next[c][`AIC_ST_OVER] = 1'b1;
                        end
                    end
                    if (cal_fault_i) begin
                        stat_next[c][`AIC_ST_INVALID] = 1'b1; // RQ17
                        stat_next[c][`AIC_ST_CAL] = 1'b1;
                    end
                    // fault count limit only means something while suppression runs
                    if (!cfg_reg[c][`AIC_BIT_NOSUP] && fcnt_next[c] >= 4'(`AIC_FAULT_LIMIT)) begin
                        stat_next[c][`AIC_ST_INVALID] = 1'b1; // RQ17
                        stat_next[c][`AIC_ST_FLIM] = 1'b1;
                    end
                    pv_next[c] = cfg_reg[c][`AIC_BIT_OFF] ? 16'sh0 : sc; // RQ5
                end
            end
        end
        if (req_valid_i) begin
            rsp_valid_next = 1'b1;
            rsp_err_next = 1'b1;
            rsp_data_next = 16'h0;
            for (int c = 0; c < NCH; c++) begin
                if (4'(c) == req_i.sub && 32'(req_i.sub) < NCH) begin
                    rsp_err_next = 1'b0;
                    unique case (req_i.idx)
                        `AIC_IDX_RAW: begin
                            rsp_data_next = raw_reg[c]; // RQ1
                            rsp_err_next = req_write_i;
                        end
                        `AIC_IDX_CFG: begin
                            rsp_data_next = cfg_reg[c];
                            // whole word write, so a single-bit change needs the current type written back with it
                            if (req_write_i) begin
                                cfg_next[c] = req_i.data; // RQ2 RQ6
                            end
                        end
                        `AIC_IDX_UNIT: begin
                            rsp_data_next = unit_reg[c];
                            if (req_write_i) unit_next[c] = req_i.data; // RQ15 RQ16
                        end
                        `AIC_IDX_PV: begin
                            rsp_data_next = cfg_reg[c][`AIC_BIT_OFF] ? 16'h0
                                                                      : pv_reg[c]; // RQ5 RQ9
                            rsp_err_next = req_write_i;
                        end
                        `AIC_IDX_STAT: begin
                            rsp_data_next = {8'h0, stat_reg[c]}; // RQ17
                            rsp_err_next = req_write_i;
                        end
                        default: rsp_err_next = 1'b1;
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int c = 0; c < NCH; c++) begin
                raw_reg[c] <= 16'h0;
                cfg_reg[c] <= `AIC_CFG_RST;
                unit_reg[c] <= `AIC_UNIT_RST;
                pv_reg[c] <= 16'sh0;
                stat_reg[c] <= 8'h0;
                fcnt_reg[c] <= 4'h0;
                age_reg[c] <= 32'hffffffff;
            end
            rsp_valid_reg <= 1'b0;
            rsp_err_reg <= 1'b0;
            rsp_data_reg <= 16'h0;
        end else if (ce_i) begin
            for (int c = 0; c < NCH; c++) begin
                raw_reg[c] <= raw_next[c];
                cfg_reg[c] <= cfg_next[c];
                unit_reg[c] <= unit_next[c];
                pv_reg[c] <= pv_next[c];
                stat_reg[c] <= stat_next[c];
                fcnt_reg[c] <= fcnt_next[c];
                age_reg[c] <= age_next[c];
            end
            rsp_valid_reg <= rsp_valid_next;
            rsp_err_reg <= rsp_err_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_err_o = rsp_err_reg;
    assign rsp_data_o = rsp_data_reg;

    // ************************************************************
    // checks
    // ************************************************************
    // checks watch channel 0, except the write refusal checks, which take any channel; the bench steers its fault, off and pulse cases there
    sequence pv_read_s;
        req_valid_i && ce_i && !req_write_i && req_i.idx == `AIC_IDX_PV && req_i.sub == 4'h0;
    endsequence
    inactive_zero_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ5
        pv_read_s ##0 cfg_reg[0][`AIC_BIT_OFF] |=> rsp_valid_o && rsp_data_o == 16'h0)
        else $error("inactive channel reported nonzero value");
    raw_capture_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ1
        sample_valid_i && ce_i && sample_ch_i == 4'h0 |=> raw_reg[0] == $past(sample_i))
        else $error("raw value not captured");
    raw_readonly_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ1
        req_valid_i && ce_i && req_write_i && req_i.idx == `AIC_IDX_RAW |=> rsp_err_o)
        else $error("write to raw value accepted");
    cfg_write_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ6
        req_valid_i && ce_i && req_write_i && req_i.idx == `AIC_IDX_CFG && req_i.sub == 4'h0
        |=> cfg_reg[0] == $past(req_i.data))
        else $error("configuration write lost");
    break_high_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ3
        sample_valid_i && ce_i && sample_ch_i == 4'h0 && sensor_fault_i
        && !cfg_reg[0][`AIC_BIT_OFF] && !cfg_reg[0][`AIC_BIT_LOWLIM] && cfg_reg[0][7:0] == 8'h1e
        |=> pv_reg[0] == 16'sd8500)
        else $error("sensor break did not give upper limit");
    break_low_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ14
        sample_valid_i && ce_i && sample_ch_i == 4'h0 && sensor_fault_i
        && !cfg_reg[0][`AIC_BIT_OFF] && cfg_reg[0][`AIC_BIT_LOWLIM] && cfg_reg[0][7:0] == 8'h1e
        |=> pv_reg[0] == -16'sd2000 && stat_reg[0][0])
        else $error("sensor break did not give lower limit");
    volt_scale_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ12
        sample_valid_i && ce_i && sample_ch_i == 4'h0 && !sensor_fault_i && sample_i == 16'h0
        && cfg_reg[0][15:0] == 16'h4028 |=> pv_reg[0] == 16'sh0)
        else $error("voltage zero not scaled to zero");
    unit_keep_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ15
        !(req_valid_i && req_write_i) && ce_i |=> $stable(unit_reg[0]))
        else $error("unit code changed without a write");
    sequence ch0_sample_s;
        sample_valid_i && ce_i && sample_ch_i == 4'h0;
    endsequence
    raw_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ1
        !ce_i |=> $stable(raw_reg[0]) && $stable(pv_reg[0]))
        else $error("state moved while clock enable low");
    pv_readonly_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ9
        req_valid_i && ce_i && req_write_i && req_i.idx == `AIC_IDX_PV |=> rsp_err_o)
        else $error("write to process value accepted");
    stat_write_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ17
        req_valid_i && ce_i && req_write_i && req_i.idx == `AIC_IDX_STAT |=> rsp_err_o)
        else $error("write to status accepted");
    unit_write_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ16
        req_valid_i && ce_i && req_write_i && req_i.idx == `AIC_IDX_UNIT && req_i.sub == 4'h0
        |=> unit_reg[0] == $past(req_i.data))
        else $error("unit code write lost");
    cal_status_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ17
        ch0_sample_s ##0 cal_fault_i
        |=> stat_reg[0][`AIC_ST_CAL] && stat_reg[0][`AIC_ST_INVALID])
        else $error("calibration fault not flagged");
    fault_status_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ14
        ch0_sample_s ##0 sensor_fault_i |=> stat_reg[0][`AIC_ST_INVALID]
        && (stat_reg[0][`AIC_ST_OVER] || stat_reg[0][`AIC_ST_UNDER]))
        else $error("sensor fault not flagged");
    status_valid_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ17
        stat_reg[0][`AIC_ST_FLIM:`AIC_ST_OVER] != 4'h0 |-> stat_reg[0][`AIC_ST_INVALID])
        else $error("status event without invalid flag");
    limit_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ17
        ch0_sample_s ##0 cfg_reg[0][`AIC_BIT_NOSUP] |=> !stat_reg[0][`AIC_ST_FLIM])
        else $error("fault limit flagged with suppression off");
    pulse_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // RQ8
        ch0_sample_s ##0 (!cfg_reg[0][`AIC_BIT_NOSUP] && !cfg_reg[0][`AIC_BIT_OFF]
        && !sensor_fault_i && age_reg[0] <= 32'(SCAN_MIN_CYC) * 8
        && 32'(sample_i > raw_reg[0] ? sample_i - raw_reg[0] : raw_reg[0] - sample_i) * 100
        > `AIC_SPIKE_PCT * 65536) |=> pv_reg[0] == $past(pv_reg[0]))
        else $error("interference pulse reached process value");
endmodule

// *** src/aic_params.svh ***
// constants for the analog input channel block: object indices, field positions, defaults, timing
// assumes a 40 MHz clock; included by design module and testbench
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH
`define AIC_IDX_RAW 16'h6100
`define AIC_IDX_CFG 16'h6110
`define AIC_IDX_UNIT 16'h6131
`define AIC_IDX_PV 16'h7130
`define AIC_IDX_STAT 16'h6150
`define AIC_BIT_LOWLIM 13
`define AIC_BIT_NOSUP 14
`define AIC_BIT_OFF 15
`define AIC_CFG_RST 16'h001e
`define AIC_UNIT_RST 16'h301f
`define AIC_ST_INVALID 0
`define AIC_ST_OVER 1
`define AIC_ST_UNDER 2
`define AIC_ST_CAL 3
`define AIC_ST_FLIM 4
`define AIC_SPIKE_PCT 5
`define AIC_SCAN_MIN_MS 25
`define AIC_SCAN_MAX_MS 200
`define AIC_CLK_HZ 40000000
`define AIC_SCAN_MIN_CYC ((`AIC_SCAN_MIN_MS * `AIC_CLK_HZ) / 1000)
`define AIC_FAULT_LIMIT 8
`endif

// *** src/aic_pkg.sv ***
// types for the analog input channel block
// constants live in aic_params.svh
package aic_pkg;
    typedef enum logic [7:0] {
        AIC_TC_J = 8'h01, AIC_TC_K = 8'h02, AIC_TC_L = 8'h03, AIC_TC_E = 8'h04,
        AIC_TC_T = 8'h05, AIC_TC_S = 8'h06, AIC_TC_R = 8'h07, AIC_TC_B = 8'h08,
        AIC_TC_N = 8'h09, AIC_TC_W = 8'h0a, AIC_RTD = 8'h1e, AIC_V_UNI = 8'h28,
        AIC_V_BI = 8'h29, AIC_I_420 = 8'h33, AIC_I_020 = 8'h34
    } aic_sensor_t;
    typedef struct packed {
        logic [15:0] idx;
        logic [3:0] sub;
        logic [15:0] data;
    } aic_obj_req_t;
    typedef struct packed {
        logic [11:0] code;
        logic [3:0] factor;
    } aic_unit_t;
endpackage

// *** verification/aic_master_model.sv ***
// far-side master model: issues object reads and writes to the channel block
// assumes requests launch 2 ns after the rising edge of clk_i
`timescale 1ns/1ps
module aic_master_model (
    input wire logic clk_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_err_i,
    input wire logic [15:0] rsp_data_i,
    output logic req_valid_o,
    output logic req_write_o,
    output aic_pkg::aic_obj_req_t req_o
);
    import aic_pkg::*;
    // ****
    // request driver
    // ****
    initial begin
        req_valid_o = 1'b0;
        req_write_o = 1'b0;
        req_o = '0;
    end
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [3:0] sub,
                        input logic [15:0] din, output logic err, output logic [15:0] dout);
        int n;
        @(posedge clk_i);
        #2;
        req_valid_o = 1'b1;
        req_write_o = w;
        req_o = '{idx: idx, sub: sub, data: din};
        @(posedge clk_i);
        #2;
        req_valid_o = 1'b0;
        // released lines show junk so a stale request cannot pass
        req_o = ~req_o;
        req_write_o = ~w;
        n = 0;
        while (rsp_valid_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        err = (n == 0) ? rsp_err_i : 1'bx;
        dout = rsp_data_i;
    endtask
endmodule

// *** verification/aic_channels_tb.sv ***
// testbench for the analog input channel block: integer model of scaling, limits, status
// assumes aic_master_model issues object requests; samples are driven by the bench
`timescale 1ns/1ps
`include "aic_params.svh"
module aic_channels_tb;
    import aic_pkg::*;
    // ****
    // signals and model
    // ****
    localparam int SCAN = 10; // short scan: pulse window is 80 cycles
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic req_valid_i, req_write_i, rsp_valid_o, rsp_err_o, e;
    logic sample_valid_i = 1'b0;
    logic sensor_fault_i = 1'b0;
    logic cal_fault_i = 1'b0;
    logic [3:0] sample_ch_i = 4'h0;
    logic [15:0] sample_i = 16'h0;
    logic [15:0] rsp_data_o, d;
    logic [31:0] seed = 32'ha47e14f3;
    aic_obj_req_t req_i;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int cfg_m[16], pv_m[16], raw_m[16], last_t[16], st_m[16];
    int codes[$] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 30, 40, 41, 51, 52};
    logic [15:0] bad[4] = '{16'h6100, 16'h7130, 16'h6150, 16'h6120};
    logic [15:0] spk[4] = '{16'h1000, 16'h1ccc, 16'h29cc, 16'h1ccc};

    aic_channels #(.SCAN_MIN_CYC(SCAN)) u_aic_channels (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_i(req_i), .sample_valid_i(sample_valid_i),
        .sample_ch_i(sample_ch_i), .sample_i(sample_i), .sensor_fault_i(sensor_fault_i),
        .cal_fault_i(cal_fault_i), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
        .rsp_data_o(rsp_data_o));
    aic_master_model u_aic_master_model (
        .clk_i(clk_i), .rsp_valid_i(rsp_valid_o), .rsp_err_i(rsp_err_o),
        .rsp_data_i(rsp_data_o), .req_valid_o(req_valid_i), .req_write_o(req_write_i),
        .req_o(req_i));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ****
    // tasks
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int lim(input int code, input bit hi);
        case (code)
            30: return hi ? 8500 : -2000;
            40: return hi ? 10000 : 0;
            41: return hi ? 10000 : -10000;
            51: return hi ? 16000 : 0;
            52: return hi ? 20000 : 0;
            default: return hi ? 22993 : -2700;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] idx, input int ch,
                       input logic [15:0] din, input logic xe, input logic [15:0] xd);
        u_aic_master_model.xfer(w, idx, 4'(ch), din, e, d);
        check({15'h0, e}, {15'h0, xe});
        check(d, xd);
    endtask
    task automatic setcfg(input int ch, input logic [15:0] v);
        acc(1'b1, `AIC_IDX_CFG, ch, v, 1'b0, 16'(cfg_m[ch]));
        cfg_m[ch] = v;
    endtask
    task automatic smp(input int ch, input logic [15:0] v, input logic f, input logic cf);
        int c;
        int s;
        bit sp;
        c = cfg_m[ch];
        s = int'(v) - raw_m[ch];
        if (s < 0)
            s = -s;
        sp = c[14] == 0 && cyc - last_t[ch] < 8 * SCAN && s * 100 > `AIC_SPIKE_PCT * 65536;
        @(posedge clk_i);
        #2;
        {sample_valid_i, sample_ch_i, sample_i} = {1'b1, 4'(ch), v};
        {sensor_fault_i, cal_fault_i} = {f, cf};
        @(posedge clk_i);
        #2;
        {sample_valid_i, sample_i} = {1'b0, ~v};
        if (f)
            pv_m[ch] = lim(c % 256, !c[13]);
        else if (!sp)
            pv_m[ch] = lim(c % 256, 0) +
                int'((longint'(lim(c % 256, 1) - lim(c % 256, 0)) * v) >>> 16);
        if (c[15])
            pv_m[ch] = 0;
        st_m[ch] = f ? (c[13] ? 5 : 3) : (cf ? 9 : 0);
        raw_m[ch] = v;
        last_t[ch] = cyc;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        int ch;
        repeat (5) @(posedge clk_i);
        #2;
        check({15'h0, rsp_valid_o}, 16'h0);
        srst_i = 1'b0;
        for (ch = 0; ch < 16; ch++) begin
            cfg_m[ch] = 30;
            last_t[ch] = -1000;
            acc(1'b0, `AIC_IDX_CFG, ch, 16'h0, 1'b0, 16'h001e);
            acc(1'b0, `AIC_IDX_UNIT, ch, 16'h0, 1'b0, 16'h301f);
            acc(1'b0, `AIC_IDX_RAW, ch, 16'h0, 1'b0, 16'h0);
        end
        $display("test done: reset values");
        foreach (bad[i])
            acc(1'b1, bad[i], 2, 16'h5a5a, 1'b1, 16'h0);
        acc(1'b0, 16'h6120, 2, 16'h0, 1'b1, 16'h0);
        acc(1'b1, `AIC_IDX_UNIT, 0, 16'h611c, 1'b0, 16'h301f);
        acc(1'b0, `AIC_IDX_UNIT, 0, 16'h0, 1'b0, 16'h611c);
        $display("test done: refusals and unit code");
        foreach (codes[i]) begin
            r = rnd();
            ch = int'(r[3:0]);
            setcfg(ch, 16'h4000 | {2'b00, r[4], 13'h0} | 16'(codes[i]));
            for (int k = 0; k < 3; k++) begin
                v = (k == 0) ? 16'h0 : (k == 1) ? 16'hffff : r[31:16];
                smp(ch, v, 1'b0, 1'b0);
                acc(1'b0, `AIC_IDX_PV, ch, 16'h0, 1'b0, 16'(pv_m[ch]));
                acc(1'b0, `AIC_IDX_RAW, ch, 16'h0, 1'b0, v);
            end
        end
        $display("test done: sensor scaling");
        for (int b = 0; b < 2; b++) begin
            setcfg(0, 16'h401e | 16'(b << 13));
            smp(0, 16'h8000, 1'b1, 1'b0);
            acc(1'b0, `AIC_IDX_PV, 0, 16'h0, 1'b0, 16'(pv_m[0]));
            acc(1'b0, `AIC_IDX_STAT, 0, 16'h0, 1'b0, 16'(st_m[0]));
        end
        smp(0, 16'h1234, 1'b0, 1'b1);
        acc(1'b0, `AIC_IDX_STAT, 0, 16'h0, 1'b0, 16'(st_m[0]));
        smp(0, 16'h1234, 1'b0, 1'b0);
        acc(1'b0, `AIC_IDX_STAT, 0, 16'h0, 1'b0, 16'(st_m[0]));
        $display("test done: faults");
        setcfg(0, 16'h4028);
        acc(1'b0, `AIC_IDX_CFG, 0, 16'h0, 1'b0, 16'h4028);
        setcfg(0, d | 16'h8000);
        smp(0, 16'hc000, 1'b0, 1'b0);
        acc(1'b0, `AIC_IDX_PV, 0, 16'h0, 1'b0, 16'(pv_m[0]));
        setcfg(0, 16'(cfg_m[0]) & 16'h7fff);
        acc(1'b0, `AIC_IDX_CFG, 0, 16'h0, 1'b0, 16'h4028);
        for (int k = 0; k < 2; k++) begin
            smp(0, (k == 0) ? 16'hc000 : 16'h0, 1'b0, 1'b0);
            acc(1'b0, `AIC_IDX_PV, 0, 16'h0, 1'b0, 16'(pv_m[0]));
        end
        $display("test done: channel off");
        setcfg(0, 16'h001e);
        repeat (100) @(posedge clk_i);
        foreach (spk[i]) begin
            if (i == 3)
                setcfg(0, 16'h401e);
            smp(0, spk[i], 1'b0, 1'b0);
            acc(1'b0, `AIC_IDX_PV, 0, 16'h0, 1'b0, 16'(pv_m[0]));
        end
        $display("test done: pulse suppression");
        @(posedge clk_i);
        #2;
        ce_i = 1'b0;
        {sample_valid_i, sample_ch_i, sample_i} = {1'b1, 4'h0, 16'h5a5a};
        @(posedge clk_i);
        #2;
        {ce_i, sample_valid_i} = 2'b10;
        acc(1'b0, `AIC_IDX_RAW, 0, 16'h0, 1'b0, 16'(raw_m[0]));
        $display("test done: clock enable");
        end_of_test();
    end
endmodule
